// *** rtl/dbrf_pkg.sv ***
package dbrf_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned IDX_W       = 4;
  localparam int unsigned BANK_REGS   = 15;
  localparam logic [3:0]  STACK_IDX   = 4'hF;
  localparam logic        BANK_GP     = 1'b0;
  localparam logic        BANK_PIX    = 1'b1;
  localparam logic [31:0] RESET_WORD  = 32'h0000_0000;
  localparam logic [5:0]  SHIFT_MAX   = 6'h20;

  // ----------------------------------------------------------------
  // operations
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    DBRF_OP_PASS = 4'h0,
    DBRF_OP_ADD  = 4'h1,
    DBRF_OP_SUB  = 4'h2,
    DBRF_OP_AND  = 4'h3,
    DBRF_OP_OR   = 4'h4,
    DBRF_OP_XOR  = 4'h5,
    DBRF_OP_NOT  = 4'h6,
    DBRF_OP_SLL  = 4'h7,
    DBRF_OP_SRL  = 4'h8,
    DBRF_OP_SRA  = 4'h9,
    DBRF_OP_ROL  = 4'hA,
    DBRF_OP_ROR  = 4'hB,
    DBRF_OP_FLD  = 4'hC
  } dbrf_op_e;

  typedef struct packed {
    logic       bank;
    logic [3:0] idx;
  } dbrf_sel_s;

  typedef struct packed {
    logic       valid;
    dbrf_op_e   op;
    dbrf_sel_s  src_a;
    dbrf_sel_s  src_b;
    dbrf_sel_s  dst;
    logic [5:0] amount;
  } dbrf_cmd_s;

  typedef struct packed {
    logic        valid;
    dbrf_sel_s   dst;
    logic [31:0] data;
    logic [5:0]  width;
  } dbrf_wb_s;

  typedef struct packed {
    logic [14:0][31:0] bank_gp;
    logic [14:0][31:0] bank_pix;
    logic [31:0]       stack;
    logic [31:0]       result;
    logic              result_valid;
  } dbrf_state_s;

endpackage

// *** rtl/dbrf_top.sv ***
// Overview of operation
// - storage is thirty-one 32-bit words, one of them the stack pointer.
// - the stack pointer is the sixteenth entry (index fifteen) of both banks, one shared copy for reads and writes.
// - bank zero holds fifteen general-purpose registers.
// - bank one holds fifteen registers that feed pixel operations and are plain registers otherwise.
// - the barrel shifter shifts or rotates left or right by 1 to 32 places in one cycle.
// - memory loads write a selectable-width field; register moves copy the whole word.
// - common arithmetic and Boolean operations finish in one cycle.
`timescale 1ns/1ns
`default_nettype none
module dbrf_top (
  input  wire logic               mclk,
  input  wire logic               rst_n,
  input  wire dbrf_pkg::dbrf_cmd_s cmd,
  input  wire dbrf_pkg::dbrf_wb_s  mem_wb,
  input  wire logic               pixel_mode,
  output logic [31:0]             result,
  output logic                    result_valid,
  output logic [31:0]             rd_a,
  output logic [31:0]             rd_b,
  output logic [31:0]             stack_pointer,
  output logic [14:0][31:0]       pixel_operands
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  dbrf_pkg::dbrf_state_s st;
  dbrf_pkg::dbrf_state_s next_st;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] dbrf_read(input dbrf_pkg::dbrf_state_s s, input dbrf_pkg::dbrf_sel_s sel);
    logic [31:0] v;
    v = dbrf_pkg::RESET_WORD;
    if (sel.idx == dbrf_pkg::STACK_IDX) begin
      v = s.stack;
    end else if (sel.bank == dbrf_pkg::BANK_GP) begin
      v = s.bank_gp[sel.idx];
    end else begin
      v = s.bank_pix[sel.idx];
    end
    return v;
  endfunction

  function automatic logic [31:0] dbrf_field(input logic [5:0] w);
    logic [31:0] m;
    m = 32'hFFFF_FFFF;
    if (w != 6'h00 && w < dbrf_pkg::SHIFT_MAX) begin
      m = ~(32'hFFFF_FFFF << w[4:0]);
    end
    return m;
  endfunction

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  // both write ports share this so the stack word is decoded in one place
  function automatic dbrf_pkg::dbrf_state_s dbrf_put(input dbrf_pkg::dbrf_state_s s,
                                                     input dbrf_pkg::dbrf_sel_s   sel,
                                                     input logic [31:0]           v);
    dbrf_pkg::dbrf_state_s n;
    n = s;
    if (sel.idx == dbrf_pkg::STACK_IDX) begin
      n.stack = v;
    end else if (sel.bank == dbrf_pkg::BANK_GP) begin
      n.bank_gp[sel.idx] = v;
    end else begin
      n.bank_pix[sel.idx] = v;
    end
    return n;
  endfunction

  // ----------------------------------------------------------------
  // barrel shifter
  // ----------------------------------------------------------------
  // amount 32 empties a logical shift, sign-fills an arithmetic one and leaves a rotate unchanged
  function automatic logic [31:0] dbrf_shift(input dbrf_pkg::dbrf_op_e op,
                                             input logic [31:0]        a,
                                             input logic [5:0]         n);
    logic [31:0] v;
    logic [63:0] rl;
    logic [63:0] rr;
    logic        full;
    full = (n >= dbrf_pkg::SHIFT_MAX);
    rl   = {a, a} << n[4:0];
    rr   = {a, a} >> n[4:0];
    v    = a;
    case (op)
      dbrf_pkg::DBRF_OP_SLL: begin
        v = full ? 32'h0000_0000 : a << n[4:0];
      end
      dbrf_pkg::DBRF_OP_SRL: begin
        v = full ? 32'h0000_0000 : a >> n[4:0];
      end
      dbrf_pkg::DBRF_OP_SRA: begin
        v = full ? {32{a[31]}} : 32'($signed(a) >>> n[4:0]);
      end
      dbrf_pkg::DBRF_OP_ROL: begin
        v = rl[63:32];
      end
      dbrf_pkg::DBRF_OP_ROR: begin
        v = rr[31:0];
      end
      default: begin
        v = a;
      end
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------
  // operand read
  // ----------------------------------------------------------------
  logic [31:0] op_a;
  logic [31:0] op_b;
  logic [31:0] alu;

  assign op_a = dbrf_read(st, cmd.src_a);
  assign op_b = dbrf_read(st, cmd.src_b);

  // ----------------------------------------------------------------
  // single-cycle execute
  // ----------------------------------------------------------------
  always_comb begin
    alu = op_a;
    unique case (cmd.op)
      dbrf_pkg::DBRF_OP_PASS: begin
        alu = op_a;
      end
      dbrf_pkg::DBRF_OP_ADD: begin
        alu = op_a + op_b;
      end
      dbrf_pkg::DBRF_OP_SUB: begin
        alu = op_a - op_b;
      end
      dbrf_pkg::DBRF_OP_AND: begin
        alu = op_a & op_b;
      end
      dbrf_pkg::DBRF_OP_OR: begin
        alu = op_a | op_b;
      end
      dbrf_pkg::DBRF_OP_XOR: begin
        alu = op_a ^ op_b;
      end
      dbrf_pkg::DBRF_OP_NOT: begin
        alu = ~op_a;
      end
      dbrf_pkg::DBRF_OP_SLL: begin
        alu = dbrf_shift(cmd.op, op_a, cmd.amount);
      end
      dbrf_pkg::DBRF_OP_SRL: begin
        alu = dbrf_shift(cmd.op, op_a, cmd.amount);
      end
      dbrf_pkg::DBRF_OP_SRA: begin
        alu = dbrf_shift(cmd.op, op_a, cmd.amount);
      end
      dbrf_pkg::DBRF_OP_ROL: begin
        alu = dbrf_shift(cmd.op, op_a, cmd.amount);
      end
      dbrf_pkg::DBRF_OP_ROR: begin
        alu = dbrf_shift(cmd.op, op_a, cmd.amount);
      end
      dbrf_pkg::DBRF_OP_FLD: begin
        alu = op_a & dbrf_field(cmd.amount);
      end
      default: begin
        alu = op_a;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state update
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0] ld_word;
    // load data is zero-extended above its field width
    ld_word = mem_wb.data & dbrf_field(mem_wb.width);
    next_st = st;
    next_st.result_valid = cmd.valid;
    if (cmd.valid) begin
      next_st.result = alu;
    end
    // the load goes first so that a same-cycle execute result to the same register wins
    if (mem_wb.valid) begin
      next_st = dbrf_put(next_st, mem_wb.dst, ld_word);
    end
    if (cmd.valid) begin
      next_st = dbrf_put(next_st, cmd.dst, alu);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign result        = st.result;
  assign result_valid  = st.result_valid;
  assign rd_a          = op_a;
  assign rd_b          = op_b;
  assign stack_pointer = st.stack;

  // ----------------------------------------------------------------
  // pixel operand gate
  // ----------------------------------------------------------------
  // pixel engines see bank one only while a pixel operation is running
  for (genvar g = 0; g < dbrf_pkg::BANK_REGS; g++) begin : g_pix
    assign pixel_operands[g] = pixel_mode ? st.bank_pix[g] : 32'h0000_0000;
  end

endmodule
`default_nettype wire

// *** test/dbrf_chk.sv ***
`timescale 1ns/1ns
`default_nettype none
module dbrf_chk (
  input wire logic                mclk,
  input wire logic                rst_n,
  input wire dbrf_pkg::dbrf_cmd_s cmd,
  input wire dbrf_pkg::dbrf_wb_s  mem_wb,
  input wire logic                pixel_mode,
  input wire logic [31:0]         result,
  input wire logic                result_valid,
  input wire logic [31:0]         rd_a,
  input wire logic [31:0]         rd_b,
  input wire logic [31:0]         stack_pointer,
  input wire logic [14:0][31:0]   pixel_operands
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  chk_vld_pulse: assert property (cmd.valid |=> result_valid) else $error("pulse");
  chk_idle_hold: assert property (!cmd.valid |=> !result_valid && $stable(result)) else $error("idle");
  chk_add_one: assert property (cmd.valid && cmd.op == 4'h1 |=> result == $past(rd_a) + $past(rd_b))
    else $error("add");
  chk_move_whole: assert property (cmd.valid && cmd.op == 4'h0 |=> result == $past(rd_a)) else $error("move");
  chk_shift_left: assert property (cmd.valid && cmd.op == 4'h7 |=> result == $past(rd_a) << $past(cmd.amount))
    else $error("shift");
  chk_sp_write: assert property (cmd.valid && cmd.dst.idx == 4'hF |=> stack_pointer == result) else $error("spw");
  chk_sp_read: assert property (cmd.src_b.idx == 4'hF |-> rd_b == stack_pointer) else $error("spr");
  chk_pix_gate: assert property (!pixel_mode |-> pixel_operands == '0) else $error("pix");
endmodule
`default_nettype wire

// *** test/dbrf_mem_ld.sv ***
`timescale 1ns/1ns
`default_nettype none
module dbrf_mem_ld (
  input  wire logic               mclk,
  input  wire logic               rst_n,
  input  wire dbrf_pkg::dbrf_wb_s req,
  output var dbrf_pkg::dbrf_wb_s  mem_wb
);
  // a load lands one state after its request, like a one-deep field queue
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) mem_wb <= '0;
    else mem_wb <= req;
  end
endmodule
`default_nettype wire

// *** test/testbench.sv ***
`timescale 1ns/1ns
`default_nettype none
`define CHK(a,e) begin checked++; if ((a) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module testbench;
  logic                mclk, rst_n, pixel_mode, result_valid, vld;
  dbrf_pkg::dbrf_cmd_s cmd, c;
  dbrf_pkg::dbrf_wb_s  req, mem_wb, r;
  logic [31:0]         result, rd_a, rd_b, stack_pointer, exp_res, m [31];
  logic [14:0][31:0]   pixel_operands;
  int                  n_mismatch, checked, k;
  dbrf_top DUT (
    .mclk           (mclk),
    .rst_n          (rst_n),
    .cmd            (cmd),
    .mem_wb         (mem_wb),
    .pixel_mode     (pixel_mode),
    .result         (result),
    .result_valid   (result_valid),
    .rd_a           (rd_a),
    .rd_b           (rd_b),
    .stack_pointer  (stack_pointer),
    .pixel_operands (pixel_operands)
  );
  dbrf_mem_ld P (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .req    (req),
    .mem_wb (mem_wb)
  );
  // slot 30 is the one shared stack word
  function automatic int ix(dbrf_pkg::dbrf_sel_s s);
    return (s.idx == 4'hF) ? 30 : s.bank * 15 + s.idx;
  endfunction
  // case items follow the op order of the package
  function automatic logic [31:0] alu(logic [3:0] op, logic [31:0] a, b, logic [5:0] n);
    case (op)
      4'h1: return a + b;
      4'h2: return a - b;
      4'h3: return a & b;
      4'h4: return a | b;
      4'h5: return a ^ b;
      4'h6: return ~a;
      4'h7: return a << n;
      4'h8: return a >> n;
      4'h9: return 32'($signed(a) >>> n);
      4'hA: return (a << n) | (a >> (32 - n));
      4'hB: return (a >> n) | (a << (32 - n));
      4'hC: return (n == 0 || n >= 32) ? a : a & (32'hFFFFFFFF >> (32 - n));
      default: return a;
    endcase
  endfunction
  task automatic print_verdict();
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    mclk = 0;
    forever #20 mclk = ~mclk;
  end
  initial begin
    #200000;
    n_mismatch++;
    print_verdict();
  end
  initial begin
    rst_n = 1'b0;
    void'($urandom(32'hCEF0CB6E));
    for (int p = 0; p < 2; p++) begin
      // the second pass resets in mid-run with the registers full of random data
      if (p > 0) begin
        @(posedge mclk);
        rst_n <= 1'b0;
      end
      cmd        <= '0;
      req        <= '0;
      pixel_mode <= 1'b1;
      exp_res = '0;
      foreach (m[i]) m[i] = '0;
      repeat (5) @(posedge mclk);
      @(negedge mclk);
      `CHK(result_valid, 1'b0)
      `CHK(result, 32'h0)
      `CHK(stack_pointer, 32'h0)
      `CHK(rd_a, 32'h0)
      for (int j = 0; j < 15; j++) `CHK(pixel_operands[j], 32'h0)
      @(posedge mclk);
      rst_n <= 1'b1;
      for (int i = 0; i < 1000; i++) begin
        @(posedge mclk);
        vld = cmd.valid;
        if (vld) exp_res = alu(cmd.op, m[ix(cmd.src_a)], m[ix(cmd.src_b)], cmd.amount);
        if (mem_wb.valid) m[ix(mem_wb.dst)] = alu(4'hC, mem_wb.data, '0, mem_wb.width);
        if (vld) m[ix(cmd.dst)] = exp_res;
        c = 26'($urandom);
        c.op = dbrf_pkg::dbrf_op_e'(4'($urandom % 13));
        c.amount = (i % 5 == 0) ? 6'h20 : 6'(1 + $urandom % 32);
        if (i % 7 == 0) c.dst.idx = 4'hF;
        // a load and an execute aimed at one register in the same cycle
        if (i % 11 == 0) begin
          c.valid = 1'b1;
          c.dst   = req.dst;
        end
        r = 44'({$urandom, $urandom});
        if (i % 11 == 10) r.valid = 1'b1;
        cmd <= c;
        req <= r;
        pixel_mode <= 1'($urandom);
        @(negedge mclk);
        k = $urandom % 15;
        `CHK(result_valid, vld)
        `CHK(result, exp_res)
        `CHK(stack_pointer, m[30])
        `CHK(rd_a, m[ix(cmd.src_a)])
        `CHK(rd_b, m[ix(cmd.src_b)])
        `CHK(pixel_operands[k], pixel_mode ? m[15 + k] : 32'h0)
      end
    end
    print_verdict();
  end
endmodule
bind dbrf_top dbrf_chk u_chk (
  .mclk           (mclk),
  .rst_n          (rst_n),
  .cmd            (cmd),
  .mem_wb         (mem_wb),
  .pixel_mode     (pixel_mode),
  .result         (result),
  .result_valid   (result_valid),
  .rd_a           (rd_a),
  .rd_b           (rd_b),
  .stack_pointer  (stack_pointer),
  .pixel_operands (pixel_operands)
);
`default_nettype wire
